/* hdl/lpcfc_regs.vh */
// Constants for the loop port credit flow control block
`ifndef LPCFC_REGS_VH
`define LPCFC_REGS_VH
`define LPCFC_CRED_W      8
`define LPCFC_CRED_ZERO   8'h00
`define LPCFC_CRED_ONE    8'h01
`define LPCFC_DATA_W      32
`define LPCFC_FIFO_DEPTH  16
`define LPCFC_FIFO_AW     4
`define LPCFC_CNT_W       5
`define LPCFC_ST_IDLE     3'h0
`define LPCFC_ST_OPEN     3'h1
`define LPCFC_ST_XFER     3'h2
`define LPCFC_ST_HOLD     3'h3
`define LPCFC_ST_CLOSE    3'h4
`define LPCFC_ST_W        3
`define LPCFC_PORT_A      1'b0
`define LPCFC_PORT_B      1'b1
`define LPCFC_MODE_DENY   1'b0
`define LPCFC_MODE_SHARE  1'b1
`endif

/* hdl/lpcfc_fifo.v */
// Frame word FIFO with valid/ready on both sides
`timescale 1ns/100ps
module lpcfc_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             clk_in,
  input  wire             sys_rst_in,
  // Fill side
  input  wire [WIDTH-1:0] wr_data_in,
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  // Drain side
  output wire [WIDTH-1:0] rd_data_out,
  output wire             rd_valid_out,
  input  wire             rd_ready_in
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      count_ff;
  wire            do_wr;
  wire            do_rd;

  assign wr_ready_out = (count_ff != DEPTH[AW:0]);
  assign rd_valid_out = (count_ff != {(AW+1){1'b0}});
  assign rd_data_out  = mem[rd_ptr_ff];
  assign do_wr        = wr_valid_in & wr_ready_out;
  assign do_rd        = rd_valid_out & rd_ready_in;

  always @(posedge clk_in) begin
    if (do_wr) begin
      mem[wr_ptr_ff] <= wr_data_in;
    end
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_rd) begin
        rd_ptr_ff <= rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_wr & ~do_rd) begin
        count_ff <= count_ff + {{AW{1'b0}}, 1'b1};
      end else if (do_rd & ~do_wr) begin
        count_ff <= count_ff - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

/* hdl/lpcfc_top.v */
// Loop port credit and circuit open/close control
`timescale 1ns/100ps
`include "lpcfc_regs.vh"
module lpcfc_top (
  // Clock and reset
  input  wire                     clk_in,
  input  wire                     sys_rst_in,
  // Configuration
  input  wire [`LPCFC_CRED_W-1:0] peer_login_credit_in,
  input  wire [`LPCFC_CRED_W-1:0] own_login_credit_in,
  input  wire                     implicit_credit_in,
  input  wire                     dual_mode_in,
  // Circuit control from local logic
  input  wire                     open_req_in,
  input  wire                     close_req_in,
  input  wire                     fwd_cls_req_in,
  input  wire [`LPCFC_CNT_W-1:0]  rx_free_bufs_in,
  // Link events
  input  wire                     rrdy_rx_in,
  input  wire                     opn_ack_in,
  input  wire                     cls_rx_in,
  input  wire                     peer_open_a_in,
  input  wire                     peer_open_b_in,
  input  wire                     peer_cmd_b_in,
  // Link requests
  output reg                      opn_tx_out,
  output reg                      half_duplex_out,
  output reg                      cls_tx_out,
  output reg                      cls_reply_b_out,
  output reg                      cmd_accept_b_out,
  output reg                      port_a_owner_out,
  output reg                      port_b_owner_out,
  // Frame data in
  input  wire [`LPCFC_DATA_W-1:0] frame_data_in,
  input  wire                     frame_valid_in,
  output wire                     frame_ready_out,
  // Frame data to link
  output reg  [`LPCFC_DATA_W-1:0] tx_data_out,
  output reg                      tx_valid_out,
  input  wire                     tx_ready_in,
  // Status
  output reg  [`LPCFC_CRED_W-1:0] avail_credit_out,
  output reg                      circuit_open_out
);
  reg [`LPCFC_ST_W-1:0]   state_ff;
  reg [`LPCFC_ST_W-1:0]   nxt_state;
  reg [`LPCFC_CRED_W-1:0] credit_ff;
  reg [`LPCFC_CRED_W-1:0] nxt_credit;
  reg [`LPCFC_CRED_W-1:0] discard_ff;
  reg [`LPCFC_CRED_W-1:0] nxt_discard;
  reg                     owner_ff;
  reg                     owner_valid_ff;
  wire [`LPCFC_DATA_W-1:0] q_data;
  wire                    q_valid;
  wire                    q_ready;
  wire                    send_frame;
  wire                    rrdy_counts;
  wire                    cls_ok;
  wire                    a_busy;

  lpcfc_fifo #(
    .WIDTH(`LPCFC_DATA_W),
    .DEPTH(`LPCFC_FIFO_DEPTH),
    .AW   (`LPCFC_FIFO_AW)
  ) u_fifo (
    .clk_in      (clk_in),
    .sys_rst_in  (sys_rst_in),
    .wr_data_in  (frame_data_in),
    .wr_valid_in (frame_valid_in),
    .wr_ready_out(frame_ready_out),
    .rd_data_out (q_data),
    .rd_valid_out(q_valid),
    .rd_ready_in (q_ready)
  );

  // Frame may leave only with positive credit and output slot free
  assign send_frame = (state_ff == `LPCFC_ST_XFER) && q_valid &&
                      (credit_ff != `LPCFC_CRED_ZERO) &&
                      (~tx_valid_out || tx_ready_in);
  assign q_ready    = send_frame;
  // R_RDY counts unless it is one of the discarded ones
  assign rrdy_counts = rrdy_rx_in && (discard_ff == `LPCFC_CRED_ZERO);
  // Own buffers must cover own login credit before CLS
  assign cls_ok = (own_login_credit_in == `LPCFC_CRED_ZERO) ||
                  ({{(`LPCFC_CRED_W-`LPCFC_CNT_W){1'b0}}, rx_free_bufs_in} >=
                   own_login_credit_in);
  assign a_busy = circuit_open_out || peer_open_a_in;

  always @* begin
    nxt_state   = state_ff;
    nxt_credit  = credit_ff;
    nxt_discard = discard_ff;
    case (state_ff)
      `LPCFC_ST_IDLE: begin
        if (open_req_in) begin
          nxt_state = `LPCFC_ST_OPEN;
        end
      end
      `LPCFC_ST_OPEN: begin
        if (opn_ack_in) begin
          nxt_state = `LPCFC_ST_XFER;
          if (implicit_credit_in && peer_login_credit_in != `LPCFC_CRED_ZERO) begin
            nxt_credit  = peer_login_credit_in;
            nxt_discard = peer_login_credit_in;
          end else begin
            nxt_credit  = `LPCFC_CRED_ZERO;
            nxt_discard = `LPCFC_CRED_ZERO;
          end
        end
      end
      `LPCFC_ST_XFER: begin
        if (rrdy_rx_in && discard_ff != `LPCFC_CRED_ZERO) begin
          nxt_discard = discard_ff - `LPCFC_CRED_ONE;
        end
        if (rrdy_counts && !send_frame) begin
          nxt_credit = credit_ff + `LPCFC_CRED_ONE;
        end else if (send_frame && !rrdy_counts) begin
          nxt_credit = credit_ff - `LPCFC_CRED_ONE;
        end
        if (cls_rx_in) begin
          nxt_state = `LPCFC_ST_CLOSE;
        end else if (close_req_in) begin
          nxt_state = `LPCFC_ST_HOLD;
        end
      end
      `LPCFC_ST_HOLD: begin
        // Circuit still open while CLS waits, so R_RDYs keep counting
        if (rrdy_rx_in && discard_ff != `LPCFC_CRED_ZERO) begin
          nxt_discard = discard_ff - `LPCFC_CRED_ONE;
        end
        if (rrdy_counts) begin
          nxt_credit = credit_ff + `LPCFC_CRED_ONE;
        end
        if (cls_rx_in || cls_ok) begin
          nxt_state = `LPCFC_ST_CLOSE;
        end
      end
      `LPCFC_ST_CLOSE: begin
        nxt_state   = `LPCFC_ST_IDLE;
        nxt_credit  = `LPCFC_CRED_ZERO;
        nxt_discard = `LPCFC_CRED_ZERO;
      end
      default: begin
        nxt_state = `LPCFC_ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_ff         <= `LPCFC_ST_IDLE;
      credit_ff        <= `LPCFC_CRED_ZERO;
      discard_ff       <= `LPCFC_CRED_ZERO;
      opn_tx_out       <= 1'b0;
      half_duplex_out  <= 1'b0;
      cls_tx_out       <= 1'b0;
      avail_credit_out <= `LPCFC_CRED_ZERO;
      circuit_open_out <= 1'b0;
      tx_data_out      <= {`LPCFC_DATA_W{1'b0}};
      tx_valid_out     <= 1'b0;
    end else begin
      state_ff         <= nxt_state;
      credit_ff        <= nxt_credit;
      discard_ff       <= nxt_discard;
      avail_credit_out <= nxt_credit;
      circuit_open_out <= (nxt_state == `LPCFC_ST_XFER) || (nxt_state == `LPCFC_ST_HOLD);
      opn_tx_out       <= (state_ff == `LPCFC_ST_IDLE) && open_req_in;
      if ((state_ff == `LPCFC_ST_IDLE) && open_req_in) begin
        half_duplex_out <= (own_login_credit_in != `LPCFC_CRED_ZERO) ||
                           (peer_login_credit_in != `LPCFC_CRED_ZERO);
      end
      cls_tx_out <= (state_ff == `LPCFC_ST_HOLD) && !cls_rx_in && cls_ok ||
                    (fwd_cls_req_in && cls_ok);
      if (send_frame) begin
        tx_data_out  <= q_data;
        tx_valid_out <= 1'b1;
      end else if (tx_ready_in) begin
        tx_valid_out <= 1'b0;
      end
    end
  end

  // Dual port resource ownership
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      owner_ff         <= `LPCFC_PORT_A;
      owner_valid_ff   <= 1'b0;
      cls_reply_b_out  <= 1'b0;
      cmd_accept_b_out <= 1'b0;
      port_a_owner_out <= 1'b0;
      port_b_owner_out <= 1'b0;
    end else begin
      if (!owner_valid_ff) begin
        if (a_busy) begin
          owner_ff       <= `LPCFC_PORT_A;
          owner_valid_ff <= 1'b1;
        end else if (peer_open_b_in) begin
          owner_ff       <= `LPCFC_PORT_B;
          owner_valid_ff <= 1'b1;
        end
      end else if ((owner_ff == `LPCFC_PORT_A) ? !a_busy : !peer_open_b_in) begin
        owner_valid_ff <= 1'b0;
      end
      cls_reply_b_out <= (dual_mode_in == `LPCFC_MODE_DENY) && peer_open_b_in &&
                         owner_valid_ff && (owner_ff == `LPCFC_PORT_A);
      cmd_accept_b_out <= peer_cmd_b_in && ((dual_mode_in == `LPCFC_MODE_SHARE) ||
                          !(owner_valid_ff && owner_ff == `LPCFC_PORT_A));
      port_a_owner_out <= owner_valid_ff && (owner_ff == `LPCFC_PORT_A);
      port_b_owner_out <= owner_valid_ff && (owner_ff == `LPCFC_PORT_B);
    end
  end
endmodule

/* verif/lpcfc_chk_sva.sv */
// Assertion checker for the loop port credit block
`timescale 1ns/100ps
module lpcfc_chk (
  input wire logic        clk_in, sys_rst_in, implicit_credit_in, opn_tx_out, half_duplex_out,
  input wire logic        cls_tx_out, tx_valid_out, tx_ready_in, rrdy_rx_in, circuit_open_out,
  input wire logic [7:0]  peer_login_credit_in, own_login_credit_in, avail_credit_out,
  input wire logic [4:0]  rx_free_bufs_in,
  input wire logic [31:0] tx_data_out
);
  logic pv_ff;
  logic pr_ff;
  wire  new_w = tx_valid_out && (!pv_ff || pr_ff);
  always @(posedge clk_in) begin
    pv_ff <= tx_valid_out && !sys_rst_in;
    pr_ff <= tx_ready_in;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_rrdy_adds: assert property (
    circuit_open_out && !implicit_credit_in && rrdy_rx_in |=> !circuit_open_out ||
    avail_credit_out == $past(avail_credit_out) + 8'h01 - {7'h00, new_w})
    else $error("credit missed a received R_RDY");
  a_send_takes: assert property (
    circuit_open_out && !rrdy_rx_in ##1 new_w && circuit_open_out |->
    avail_credit_out == $past(avail_credit_out) - 8'h01) else $error("send kept credit");
  a_no_credit: assert property (
    new_w |-> $past(avail_credit_out) != 8'h00) else $error("frame sent without credit");
  a_half_dup: assert property (
    opn_tx_out && own_login_credit_in != 8'h00 |-> half_duplex_out) else $error("full duplex");
  a_load_impl: assert property (
    $rose(circuit_open_out) && implicit_credit_in |-> avail_credit_out == peer_login_credit_in)
    else $error("implicit credit not loaded");
  a_load_expl: assert property (
    $rose(circuit_open_out) && !implicit_credit_in |-> avail_credit_out == 8'h00)
    else $error("explicit credit not zero");
  a_credit_cap: assert property (
    circuit_open_out && implicit_credit_in && peer_login_credit_in != 8'h00 |->
    avail_credit_out <= peer_login_credit_in) else $error("R_RDY credited twice");
  a_cls_guard: assert property (
    cls_tx_out && own_login_credit_in != 8'h00 |->
    {3'h0, $past(rx_free_bufs_in)} >= own_login_credit_in) else $error("early CLS");
  a_close_clear: assert property (
    $fell(circuit_open_out) |-> ##[0:1] avail_credit_out == 8'h00) else $error("credit kept");
  a_tx_hold: assert property (
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
    else $error("frame word dropped");
endmodule
bind lpcfc_top lpcfc_chk u_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .implicit_credit_in(implicit_credit_in), .opn_tx_out(opn_tx_out),
  .half_duplex_out(half_duplex_out), .cls_tx_out(cls_tx_out), .tx_valid_out(tx_valid_out),
  .tx_ready_in(tx_ready_in), .rrdy_rx_in(rrdy_rx_in), .circuit_open_out(circuit_open_out),
  .peer_login_credit_in(peer_login_credit_in), .own_login_credit_in(own_login_credit_in),
  .avail_credit_out(avail_credit_out), .rx_free_bufs_in(rx_free_bufs_in),
  .tx_data_out(tx_data_out));

/* verif/lpcfc_peer.sv */
// Far loop port model acting as open recipient
`timescale 1ns/100ps
module lpcfc_peer (
  input  wire logic       clk_in, sys_rst_in, opn_tx_in, tx_valid_in, stall_in, rrdy_en_in,
  input  wire logic [7:0] credit_in,
  output logic            opn_ack_out,
  output logic            rrdy_out,
  output wire logic       tx_ready_out
);
  logic [2:0] dly_ff;
  logic [8:0] owe_ff;
  logic       tgl_ff;
  wire        acc = tx_valid_in && !stall_in;
  wire        snd = rrdy_en_in && tgl_ff && owe_ff != 9'h000;
  assign tx_ready_out = !stall_in;
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      dly_ff <= 3'h0;
      owe_ff <= 9'h000;
      tgl_ff <= 1'b0;
      opn_ack_out <= 1'b0;
      rrdy_out <= 1'b0;
    end else begin
      tgl_ff      <= ~tgl_ff;
      rrdy_out    <= snd;
      opn_ack_out <= dly_ff == 3'h1;
      dly_ff      <= opn_tx_in ? 3'h3 : dly_ff - {2'h0, dly_ff != 3'h0};
      if (dly_ff == 3'h1)
        owe_ff <= (credit_in == 8'h00 ? 9'h001 : {1'b0, credit_in}) + {8'h00, acc};
      else
        owe_ff <= owe_ff + {8'h00, acc} - {8'h00, snd};
    end
  end
endmodule

/* verif/tb.sv */
// Self-checking bench for the loop port credit block
`timescale 1ns/100ps
module tb;
  logic        clk = 0, rst = 1, impl = 0, dual = 0, oreq = 0, creq = 0, fv = 0;
  logic        stall = 1, ren = 0, pa = 0, pb = 0, cb = 0, fwd = 0, crx = 0;
  logic [7:0]  pcr = 0, ocr = 0;
  logic [4:0]  fb = 5'h1f;
  logic [31:0] fd = 0, nin = 32'hA000_0000, nrx = 32'hA000_0000;
  wire  [31:0] txd;
  wire  [7:0]  av;
  wire         otx, hdx, ctx, crb, cab, oa, ob, fr, txv, txr, ack, rrdy, co;
  int          num_errors = 0, num_checks = 0, cyc = 0, i;
  always #12.5 clk = ~clk;
  lpcfc_top u_dut (.clk_in(clk), .sys_rst_in(rst), .peer_login_credit_in(pcr),
    .own_login_credit_in(ocr), .implicit_credit_in(impl), .dual_mode_in(dual),
    .open_req_in(oreq), .close_req_in(creq), .fwd_cls_req_in(fwd), .rx_free_bufs_in(fb),
    .rrdy_rx_in(rrdy), .opn_ack_in(ack), .cls_rx_in(crx), .peer_open_a_in(pa),
    .peer_open_b_in(pb), .peer_cmd_b_in(cb), .opn_tx_out(otx), .half_duplex_out(hdx),
    .cls_tx_out(ctx), .cls_reply_b_out(crb), .cmd_accept_b_out(cab), .port_a_owner_out(oa),
    .port_b_owner_out(ob), .frame_data_in(fd), .frame_valid_in(fv), .frame_ready_out(fr),
    .tx_data_out(txd), .tx_valid_out(txv), .tx_ready_in(txr), .avail_credit_out(av),
    .circuit_open_out(co));
  lpcfc_peer u_peer (.clk_in(clk), .sys_rst_in(rst), .opn_tx_in(otx), .tx_valid_in(txv),
    .stall_in(stall), .rrdy_en_in(ren), .credit_in(pcr), .opn_ack_out(ack), .rrdy_out(rrdy),
    .tx_ready_out(txr));
  task ck(input bit ok, input string m);
    num_checks++;
    if (!ok) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task final_report;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      final_report;
    end
    if (!rst && txv === 1'b1 && txr === 1'b1) begin
      ck(txd === nrx, "frame word order");
      nrx++;
    end
  end
  task open_circ(input logic im, input logic [7:0] p, input logic [7:0] o);
    impl = im;
    pcr = p;
    ocr = o;
    oreq = 1;
    @(negedge clk);
    oreq = 0;
    ck(otx === 1'b1 && hdx === (p != 0 || o != 0), "open request");
    for (i = 0; i < 20 && co !== 1'b1; i++) @(negedge clk);
    ck(av === (im ? p : 8'h00), "credit at open");
  endtask
  task push(input int n);
    fv = 1;
    repeat (n) begin
      fd = nin;
      for (i = 0; i < 200 && fr !== 1'b1; i++) @(negedge clk);
      @(negedge clk);
      nin++;
    end
    fv = 0;
  endtask
  task close(input logic [4:0] f);
    fb = f - 5'h01;
    creq = 1;
    @(negedge clk);
    creq = 0;
    repeat (8) @(negedge clk);
    ck(co === (ocr != 0) && ctx === 1'b0, "close held for buffers");
    fb = f;
    for (i = 0; i < 10 && co !== 1'b0; i++) @(negedge clk);
    ck(ctx === (ocr != 0), "CLS sent once buffers free");
    @(negedge clk);
    ck(co === 1'b0 && av === 8'h00, "credit cleared at close");
  endtask
  task t_implicit;
    stall = 0;
    ren = 0;
    open_circ(1, 8'h04, 8'h03);
    push(6);
    repeat (4) @(negedge clk);
    ck(nrx === nin - 2 && av === 8'h00, "login credit frames sent");
    ren = 1;
    repeat (40) @(negedge clk);
    ck(nrx === nin && av === 8'h04, "first R_RDYs dropped");
    close(5'h03);
  endtask
  task t_explicit;
    stall = 1;
    ren = 0;
    open_circ(0, 8'h02, 8'h00);
    push(16);
    ck(fr === 1'b0 && txv === 1'b0, "full buffer, no credit");
    ren = 1;
    repeat (6) @(negedge clk);
    ck(av === 8'h01 && txv === 1'b1, "credit from R_RDYs");
    stall = 0;
    for (i = 0; i < 300 && nrx !== nin; i++) @(negedge clk);
    ck(nrx === nin, "buffer drained");
    close(5'h01);
  endtask
  task t_cls;
    ocr = 8'h02;
    fb = 5'h01;
    fwd = 1;
    repeat (3) @(negedge clk);
    ck(ctx === 1'b0, "forwarded CLS held for buffers");
    fb = 5'h02;
    @(negedge clk);
    ck(ctx === 1'b1, "forwarded CLS sent");
    fwd = 0;
    open_circ(0, 8'h00, 8'h00);
    crx = 1;
    @(negedge clk);
    crx = 0;
    repeat (2) @(negedge clk);
    ck(co === 1'b0 && av === 8'h00 && ctx === 1'b0, "received CLS closes");
  endtask
  task t_dual;
    pa = 1;
    @(negedge clk);
    pb = 1;
    for (i = 0; i < 4 && crb !== 1'b1; i++) @(negedge clk);
    ck(oa === 1'b1 && ob === 1'b0 && crb === 1'b1, "first port owns");
    pb = 0;
    cb = 1;
    @(negedge clk);
    cb = 0;
    ck(cab === 1'b0, "deny mode refuses command");
    dual = 1;
    @(negedge clk);
    cb = 1;
    @(negedge clk);
    cb = 0;
    for (i = 0; i < 4 && cab !== 1'b1; i++) @(negedge clk);
    ck(cab === 1'b1, "second port takes command");
    pa = 0;
    pb = 1;
    repeat (3) @(negedge clk);
    ck(ob === 1'b1 && oa === 1'b0 && crb === 1'b0, "second port owns when first idle");
    pb = 0;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 0;
    t_implicit;
    t_explicit;
    t_cls;
    t_dual;
    final_report;
  end
endmodule
